// ==== hw/pmo_regs.svh ====
// Purpose: Timing counts and reset values for the margining pulse outputs
// Assumes: 250 MHz system clock
// Notes:   Derived counts are computed from the printed rates
`ifndef PMO_REGS_SVH
`define PMO_REGS_SVH

`define PMO_CLK_HZ 250000000
`define PMO_SLOW_SRC_HZ 15625000
`define PMO_SLOW_PRESCALE (`PMO_CLK_HZ / `PMO_SLOW_SRC_HZ)
`define PMO_SLOW1_HZ 10000
`define PMO_SLOW2_HZ 1000
`define PMO_SLOW1_DIV (`PMO_CLK_HZ / `PMO_SLOW1_HZ)
`define PMO_SLOW2_DIV (`PMO_CLK_HZ / `PMO_SLOW2_HZ)
`define PMO_FINE_HZ 238
`define PMO_FINE_LIMIT (`PMO_SLOW_SRC_HZ / `PMO_FINE_HZ)
`define PMO_DIV_MIN 2
`define PMO_SUBSTEPS 16
`define PMO_SUB_BITS 4
`define PMO_FRAC_BITS 16
`define PMO_PIN_OUT_RST 1'b0
`define PMO_FAST_OE_RST 1'b1
`define PMO_SLOW_OE_RST 1'b0

`endif

// ==== hw/pmo_pkg.sv ====
// Purpose: Types shared by the margining pulse outputs
// Assumes: Nothing beyond the header of constants
// Notes:   Enumerations only
package pmo_pkg;
    typedef enum logic [2:0] {
        PMO_FP_UNUSED, PMO_FP_PWM, PMO_FP_GPO_PUSH, PMO_FP_GPO_OD, PMO_FP_GPI
    } pmo_fast_mode_e;
    typedef enum logic [1:0] {
        PMO_MRG_DISABLE, PMO_MRG_TRI_STATE, PMO_MRG_ACTIVE_TRIM, PMO_MRG_FIXED_DUTY
    } pmo_mrg_mode_e;
    typedef enum logic [1:0] {
        PMO_RS_NOMINAL, PMO_RS_LOW, PMO_RS_HIGH
    } pmo_rail_state_e;
endpackage

// ==== hw/pmo_pwm_channel.sv ====
// Purpose: One period counter with duty compare, phase preload and sub-step edge
// Assumes: i_step marks one tick of the channel's source clock
// Notes:   Duty carries four sub-step bits below the whole-count part
`timescale 1ns/1ps
`include "pmo_regs.svh"
module pmo_pwm_channel #(
    parameter int CW = 14
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rstn,
    // Control
    input wire logic i_step,
    input wire logic i_restart,
    input wire logic [CW-1:0] i_div,
    input wire logic [CW+3:0] i_duty,
    input wire logic [CW-1:0] i_phase,
    // Output
    output logic o_pwm,
    output logic [3:0] o_sub
);
    logic [CW-1:0] cnt_reg;
    logic [CW-1:0] cnt_next;
    logic [CW-1:0] last;
    logic [CW-1:0] duty_int;
    logic [CW-1:0] phase_ok;
    logic wrap;

    // Divisors below the minimum behave as the minimum
    assign last = (i_div < CW'(`PMO_DIV_MIN)) ? CW'(`PMO_DIV_MIN - 1) : i_div - CW'(1);
    assign wrap = (cnt_reg >= last);
    assign phase_ok = (i_phase > last) ? '0 : i_phase;
    assign duty_int = i_duty[CW+3:4];
    assign cnt_next = i_restart ? phase_ok : (i_step ? (wrap ? '0 : cnt_reg + CW'(1)) : cnt_reg);

    // ------------------------------------------------------------
    // Period counter and compare
    // ------------------------------------------------------------
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            cnt_reg <= '0;
            o_pwm <= 1'b0;
            o_sub <= 4'h0;
        end else begin
            cnt_reg <= cnt_next;
            o_pwm <= (cnt_next < duty_int);
            o_sub <= (cnt_next == duty_int) ? i_duty[3:0] : 4'h0;
        end
    end
endmodule

// ==== hw/pmo_margining_outputs.sv ====
// Purpose: Fast and slow pulse outputs with open- and closed-loop margining
// Assumes: All inputs synchronous to i_clk; ADC samples arrive as valid pulses
// Notes:   Closed-loop rail r steers fast channel r
//
// Contract
// - Fast frequency is 250 MHz over 2..16383
// - Fast pairs share one divisor
// - Fast duty has sixteen sub-steps per clock
// - Unused fast pin works as general I/O
// - Fast general outputs driven low from reset
// - Pulse pin enables unassigned companion too
// - Slow one 10 kHz, slow two 1 kHz
// - Slow three, four divide 15.625 MHz
// - Slow three, four step once per tick
// - Below 238 Hz duty resolution is 1/65536
// - Slow pins are input or pulse output
// - Each fast channel has its phase offset
// - Margining by command or two input pins
// - Open-loop uses two open-drain outputs per rail
// - Closed loop trims duty to margin target
// - Duty to voltage sense set per rail
// - Tri-state idles high-Z; disable does nothing
// - Active trim holds rail at nominal
// - Fixed mode idles at constant duty
// - Margin enable margins every enabled rail
// - Direction high selects low, else high
`timescale 1ns/1ps
`include "pmo_regs.svh"
module pmo_margining_outputs #(
    parameter int FAST_W = 14,
    parameter int SLOW_W = 24,
    parameter int ADC_W = 12,
    parameter int RAILS = 4
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rstn,
    // Fast channel configuration
    input wire logic [3:0][FAST_W-1:0] i_fast_div,
    input wire logic [7:0][FAST_W+3:0] i_fast_duty,
    input wire logic [7:0][FAST_W-1:0] i_fast_phase,
    input wire pmo_pkg::pmo_fast_mode_e [7:0] i_fast_mode,
    input wire logic [7:0] i_fast_gpo,
    input wire logic [3:0] i_fast_restart,
    // Fast pins
    input wire logic [7:0] i_fast_pin,
    output logic [7:0] o_fast_out,
    output logic [7:0] o_fast_oe,
    output logic [7:0][3:0] o_fast_sub,
    output logic [7:0] o_fast_gpi,
    // Slow channel configuration
    input wire logic [3:0] i_slow_pwm_en,
    input wire logic [3:0][SLOW_W-1:0] i_slow_duty,
    input wire logic [1:0][SLOW_W-1:0] i_slow_div,
    // Slow pins
    input wire logic [3:0] i_slow_pin,
    output logic [3:0] o_slow_out,
    output logic [3:0] o_slow_oe,
    output logic [3:0] o_slow_gpi,
    // Margin selection
    input wire logic i_mrg_use_pins,
    input wire logic i_mrg_cmd_en,
    input wire logic i_mrg_cmd_low,
    input wire logic i_mrg_en_pin,
    input wire logic i_mrg_low_pin,
    // Per-rail margin configuration
    input wire logic [RAILS-1:0] i_rail_mrg_en,
    input wire pmo_pkg::pmo_mrg_mode_e [RAILS-1:0] i_rail_mode,
    input wire logic [RAILS-1:0] i_rail_rising,
    input wire logic [RAILS-1:0] i_rail_ol_en,
    input wire logic [RAILS-1:0][FAST_W+3:0] i_rail_fixed_duty,
    // Per-rail voltages
    input wire logic [RAILS-1:0] i_rail_sample_valid,
    input wire logic [RAILS-1:0][ADC_W-1:0] i_rail_vmeas,
    input wire logic [RAILS-1:0][ADC_W-1:0] i_rail_vlow,
    input wire logic [RAILS-1:0][ADC_W-1:0] i_rail_vhigh,
    input wire logic [RAILS-1:0][ADC_W-1:0] i_rail_vnom,
    // Open-loop pins and margin status
    output logic [RAILS-1:0] o_ol_up_out,
    output logic [RAILS-1:0] o_ol_up_oe,
    output logic [RAILS-1:0] o_ol_dn_out,
    output logic [RAILS-1:0] o_ol_dn_oe,
    output logic [RAILS-1:0] o_rail_margined,
    output logic [RAILS-1:0][FAST_W+3:0] o_mrg_duty
);
    import pmo_pkg::*;

    localparam int DW = FAST_W + 4;
    localparam int PW = $clog2(`PMO_SLOW_PRESCALE);

    // Decide how a fast pin is driven: {out, oe}
    function automatic logic [1:0] fast_drive(input pmo_fast_mode_e m, input logic pwm_on,
                                              input logic pwm, input logic hiz,
                                              input logic general_output_pin);
        logic [1:0] d;
        d = 2'b01;
        if (pwm_on) begin
            d = {pwm & ~hiz, ~hiz};
        end else begin
            case (m)
                PMO_FP_GPO_PUSH: d = {general_output_pin, 1'b1};
                PMO_FP_GPO_OD: d = {1'b0, ~general_output_pin};
                PMO_FP_GPI: d = 2'b00;
                default: d = 2'b01;
            endcase
        end
        return d;
    endfunction

    // Scale a 16-bit duty fraction onto a long period
    function automatic logic [SLOW_W-1:0] frac_scale(input logic [SLOW_W-1:0] div,
                                                      input logic [SLOW_W-1:0] duty);
        logic [SLOW_W+15:0] p;
        p = (SLOW_W + 16)'(div) * (SLOW_W + 16)'(duty[15:0]);
        return p[SLOW_W+15:16];
    endfunction

    // ------------------------------------------------------------
    // Margin request
    // ------------------------------------------------------------
    wire glob_en = i_mrg_use_pins ? i_mrg_en_pin : i_mrg_cmd_en;
    wire glob_low = i_mrg_use_pins ? i_mrg_low_pin : i_mrg_cmd_low;

    logic [RAILS-1:0] ctrl_active;
    logic [RAILS-1:0] rail_hiz;

    // ------------------------------------------------------------
    // Closed- and open-loop margin per rail
    // ------------------------------------------------------------
    for (genvar r = 0; r < RAILS; r++) begin : g_rail
        pmo_rail_state_e st_reg;
        pmo_rail_state_e st_next;
        logic [DW-1:0] duty_reg;
        logic [DW-1:0] duty_next;
        logic [ADC_W-1:0] target;
        logic [DW-1:0] duty_max;
        wire live = i_rail_mrg_en[r] && (i_rail_mode[r] != PMO_MRG_DISABLE);
        wire nominal = (st_reg == PMO_RS_NOMINAL);
        wire regulate = !nominal || (i_rail_mode[r] == PMO_MRG_ACTIVE_TRIM);
        wire v_under = i_rail_vmeas[r] < target;
        wire v_over = i_rail_vmeas[r] > target;
        wire go_up = i_rail_rising[r] ? v_under : v_over;
        wire go_dn = i_rail_rising[r] ? v_over : v_under;

        assign st_next = !live ? PMO_RS_NOMINAL :
                         (glob_en ? (glob_low ? PMO_RS_LOW : PMO_RS_HIGH) :
                          PMO_RS_NOMINAL);
        assign duty_max = {i_fast_div[r/2], 4'h0};

        always_comb begin
            case (st_reg)
                PMO_RS_LOW: target = i_rail_vlow[r];
                PMO_RS_HIGH: target = i_rail_vhigh[r];
                default: target = i_rail_vnom[r];
            endcase
        end

        always_comb begin
            duty_next = duty_reg;
            if (live && nominal && i_rail_mode[r] == PMO_MRG_FIXED_DUTY) begin
                duty_next = i_rail_fixed_duty[r];
            end else if (live && regulate && i_rail_sample_valid[r]) begin
                if (go_up && duty_reg < duty_max) begin
                    duty_next = duty_reg + DW'(1);
                end else if (go_dn && duty_reg != '0) begin
                    duty_next = duty_reg - DW'(1);
                end
            end
        end

        always_ff @(posedge i_clk or negedge i_rstn) begin
            if (!i_rstn) begin
                st_reg <= PMO_RS_NOMINAL;
                duty_reg <= '0;
                o_ol_up_oe[r] <= 1'b0;
                o_ol_dn_oe[r] <= 1'b0;
            end else begin
                st_reg <= st_next;
                duty_reg <= duty_next;
                // Pulling feedback to ground raises the rail, to the output lowers it
                o_ol_up_oe[r] <= i_rail_ol_en[r] && st_next == PMO_RS_HIGH;
                o_ol_dn_oe[r] <= i_rail_ol_en[r] && st_next == PMO_RS_LOW;
            end
        end

        assign o_ol_up_out[r] = 1'b0;
        assign o_ol_dn_out[r] = 1'b0;
        assign rail_hiz[r] = live && nominal && i_rail_mode[r] == PMO_MRG_TRI_STATE;
        assign ctrl_active[r] = live;
        assign o_rail_margined[r] = !nominal;
        assign o_mrg_duty[r] = duty_reg;
    end

    // ------------------------------------------------------------
    // Fast channels
    // ------------------------------------------------------------
    logic [7:0] fast_pwm;
    logic [7:0][3:0] fast_sub;
    logic [7:0] fast_on;
    logic [7:0] fast_hiz;
    logic [7:0][1:0] fast_drv;

    for (genvar c = 0; c < 8; c++) begin : g_fast
        wire [DW-1:0] duty_sel;
        if (c < RAILS) begin : g_mrg
            assign duty_sel = ctrl_active[c] ? o_mrg_duty[c] : i_fast_duty[c];
            assign fast_hiz[c] = rail_hiz[c];
        end else begin : g_plain
            assign duty_sel = i_fast_duty[c];
            assign fast_hiz[c] = 1'b0;
        end
        // The companion follows into pulse mode only while it has no job of its own
        assign fast_on[c] = (i_fast_mode[c] == PMO_FP_PWM) ||
                            (i_fast_mode[c] == PMO_FP_UNUSED &&
                             i_fast_mode[c^1] == PMO_FP_PWM);
        assign fast_drv[c] = fast_drive(i_fast_mode[c], fast_on[c], fast_pwm[c],
                                        fast_hiz[c], i_fast_gpo[c]);

        pmo_pwm_channel #(.CW(FAST_W)) u_fast (
            .i_clk(i_clk),
            .i_rstn(i_rstn),
            .i_step(1'b1),
            .i_restart(i_fast_restart[c/2]),
            .i_div(i_fast_div[c/2]),
            .i_duty(duty_sel),
            .i_phase(i_fast_phase[c]),
            .o_pwm(fast_pwm[c]),
            .o_sub(fast_sub[c])
        );
    end

    // Pins hold low and driven until configured otherwise
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_fast_out <= {8{`PMO_PIN_OUT_RST}};
            o_fast_oe <= {8{`PMO_FAST_OE_RST}};
            o_fast_sub <= '0;
            o_fast_gpi <= '0;
        end else begin
            for (int c = 0; c < 8; c++) begin
                o_fast_out[c] <= fast_drv[c][1];
                o_fast_oe[c] <= fast_drv[c][0];
                o_fast_sub[c] <= (fast_on[c] && !fast_hiz[c]) ? fast_sub[c] : 4'h0;
            end
            o_fast_gpi <= i_fast_pin;
        end
    end

    // ------------------------------------------------------------
    // Slow channels
    // ------------------------------------------------------------
    logic [PW-1:0] pre_reg;
    wire src_tick = (pre_reg == PW'(`PMO_SLOW_PRESCALE - 1));

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            pre_reg <= '0;
        end else begin
            pre_reg <= src_tick ? '0 : pre_reg + PW'(1);
        end
    end

    logic [3:0][SLOW_W-1:0] slow_div;
    logic [3:0][SLOW_W-1:0] slow_cmp;
    logic [3:0] slow_step;
    logic [3:0] slow_pwm;

    assign slow_div[0] = SLOW_W'(`PMO_SLOW1_DIV);
    assign slow_div[1] = SLOW_W'(`PMO_SLOW2_DIV);
    assign slow_div[2] = i_slow_div[0];
    assign slow_div[3] = i_slow_div[1];
    assign slow_step = {src_tick, src_tick, 2'b11};
    assign slow_cmp[0] = i_slow_duty[0];
    assign slow_cmp[1] = i_slow_duty[1];

    for (genvar s = 2; s < 4; s++) begin : g_fine
        // Long periods take a 16-bit fraction so the duty word need not track the divisor
        wire slow_long = slow_div[s] > SLOW_W'(`PMO_FINE_LIMIT);
        assign slow_cmp[s] = slow_long ? frac_scale(slow_div[s], i_slow_duty[s]) :
                                         i_slow_duty[s];
    end

    for (genvar s = 0; s < 4; s++) begin : g_slow
        pmo_pwm_channel #(.CW(SLOW_W)) u_slow (
            .i_clk(i_clk),
            .i_rstn(i_rstn),
            .i_step(slow_step[s]),
            .i_restart(!i_slow_pwm_en[s]),
            .i_div(slow_div[s]),
            .i_duty({slow_cmp[s], 4'h0}),
            .i_phase('0),
            .o_pwm(slow_pwm[s]),
            .o_sub()
        );
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_slow_out <= {4{`PMO_PIN_OUT_RST}};
            o_slow_oe <= {4{`PMO_SLOW_OE_RST}};
            o_slow_gpi <= '0;
        end else begin
            o_slow_out <= slow_pwm & i_slow_pwm_en;
            o_slow_oe <= i_slow_pwm_en;
            o_slow_gpi <= i_slow_pin;
        end
    end
endmodule

// ==== bench/pmo_margining_outputs_asserts.sv ====
// Purpose: Port-level checks for the margining pulse outputs
// Assumes: Bound to the top module; rail 0 stands for the others
// Notes:   Fast pin 4 is the push-pull output and pin 5 the open-drain one
`timescale 1ns/1ps
module pmo_margining_outputs_asserts
    import pmo_pkg::*;
#(
    parameter int RAILS = 4
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rstn,
    // Fast and slow pins
    input wire pmo_pkg::pmo_fast_mode_e [7:0] i_fast_mode,
    input wire logic [7:0] i_fast_gpo,
    input wire logic [7:0] i_fast_pin,
    input wire logic [7:0] o_fast_out,
    input wire logic [7:0] o_fast_oe,
    input wire logic [7:0] o_fast_gpi,
    input wire logic [3:0] i_slow_pwm_en,
    input wire logic [3:0] i_slow_pin,
    input wire logic [3:0] o_slow_out,
    input wire logic [3:0] o_slow_oe,
    input wire logic [3:0] o_slow_gpi,
    // Margining
    input wire logic i_mrg_use_pins,
    input wire logic i_mrg_en_pin,
    input wire logic i_mrg_low_pin,
    input wire logic [RAILS-1:0] i_rail_mrg_en,
    input wire pmo_pkg::pmo_mrg_mode_e [RAILS-1:0] i_rail_mode,
    input wire logic [RAILS-1:0] i_rail_ol_en,
    input wire logic [RAILS-1:0] o_ol_up_out,
    input wire logic [RAILS-1:0] o_ol_up_oe,
    input wire logic [RAILS-1:0] o_ol_dn_out,
    input wire logic [RAILS-1:0] o_ol_dn_oe,
    input wire logic [RAILS-1:0] o_rail_margined
);
    import pmo_pkg::*;
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rstn);
    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    push_gpo_a: assert property (i_fast_mode[4] == PMO_FP_GPO_PUSH |=>
        o_fast_oe[4] && o_fast_out[4] == $past(i_fast_gpo[4])) else $error("push output wrong");
    od_gpo_a: assert property (i_fast_mode[5] == PMO_FP_GPO_OD |=>
        !o_fast_out[5] && o_fast_oe[5] == !$past(i_fast_gpo[5])) else $error("open drain wrong");
    input_copy_a: assert property (1'b1 |=> o_fast_gpi == $past(i_fast_pin) &&
        o_slow_gpi == $past(i_slow_pin)) else $error("input copy wrong");
    slow_dir_a: assert property (1'b1 |=> o_slow_oe == $past(i_slow_pwm_en))
        else $error("slow direction wrong");
    slow_quiet_a: assert property ((o_slow_out & ~o_slow_oe) == 4'h0)
        else $error("slow input pin driven");
    pin_enable_a: assert property (i_mrg_use_pins && i_mrg_en_pin &&
        i_rail_mrg_en[0] && i_rail_mode[0] != PMO_MRG_DISABLE |=> o_rail_margined[0])
        else $error("rail not margined");
    pin_low_a: assert property (i_mrg_use_pins && i_mrg_en_pin &&
        i_mrg_low_pin && i_rail_mrg_en[0] && i_rail_ol_en[0] &&
        i_rail_mode[0] != PMO_MRG_DISABLE |=> o_ol_dn_oe[0] && !o_ol_up_oe[0])
        else $error("margin low not selected");
    rail_off_a: assert property (!i_rail_mrg_en[0] |=>
        !o_rail_margined[0] && !o_ol_up_oe[0] && !o_ol_dn_oe[0]) else $error("rail margined");
    ol_drive_a: assert property ((o_ol_up_out | o_ol_dn_out |
        (o_ol_up_oe & o_ol_dn_oe) | ((o_ol_up_oe | o_ol_dn_oe) & ~o_rail_margined)) == '0)
        else $error("open loop pins wrong");
endmodule
bind pmo_margining_outputs pmo_margining_outputs_asserts #(.RAILS(RAILS))
    pmo_margining_outputs_asserts_i (.i_clk, .i_rstn, .i_fast_mode, .i_fast_gpo, .i_fast_pin,
    .o_fast_out, .o_fast_oe, .o_fast_gpi, .i_slow_pwm_en, .i_slow_pin, .o_slow_out,
    .o_slow_oe, .o_slow_gpi, .i_mrg_use_pins, .i_mrg_en_pin, .i_mrg_low_pin, .i_rail_mrg_en,
    .i_rail_mode, .i_rail_ol_en, .o_ol_up_out, .o_ol_up_oe, .o_ol_dn_out, .o_ol_dn_oe,
    .o_rail_margined);

// ==== bench/pmo_rc_feedback.sv ====
// Purpose: Filtered margin pin and rail measurement for one rail
// Assumes: Rail voltage grows with the high time of the pin
// Notes:   One sample every 64 clocks; the reading is inverted each clock between samples
`timescale 1ns/1ps
module pmo_rc_feedback (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rstn,
    // Margin pin
    input wire logic i_pin,
    input wire logic i_oe,
    // Measurement
    output logic o_valid,
    output logic [11:0] o_vmeas
);
    logic [5:0] win_reg;
    logic [11:0] acc_reg;
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            win_reg <= 6'h0;
            acc_reg <= 12'h0;
            o_valid <= 1'b0;
            o_vmeas <= 12'h0;
        end else begin
            win_reg <= win_reg + 6'h1;
            o_valid <= (win_reg == 6'h3f);
            acc_reg <= (win_reg == 6'h3f) ? 12'h0 : acc_reg + {11'h0, i_pin & i_oe};
            // Outside the sample the bus is garbage, so it flips each cycle
            o_vmeas <= (win_reg == 6'h3f) ? acc_reg + 12'h100 : ~o_vmeas;
        end
    end
endmodule

// ==== bench/pmo_margining_outputs_test.sv ====
// Purpose: Directed checks of the margining pulse outputs
// Assumes: Inputs change at the falling edge
// Notes:   Pulse counts span whole periods, so phase does not matter, except the long-period duty check, which allows a range
`timescale 1ns/1ps
module pmo_margining_outputs_test;
    import pmo_pkg::*;
    logic i_clk;
    logic i_rstn;
    logic [3:0][13:0] i_fast_div;
    logic [7:0][17:0] i_fast_duty;
    logic [7:0][13:0] i_fast_phase;
    pmo_fast_mode_e [7:0] i_fast_mode;
    logic [7:0] i_fast_gpo, i_fast_pin, o_fast_out, o_fast_oe, o_fast_gpi;
    logic [3:0] i_fast_restart;
    logic [7:0][3:0] o_fast_sub;
    logic [3:0] i_slow_pwm_en, i_slow_pin, o_slow_out, o_slow_oe, o_slow_gpi;
    logic [3:0][23:0] i_slow_duty;
    logic [1:0][23:0] i_slow_div;
    logic i_mrg_use_pins, i_mrg_cmd_en, i_mrg_cmd_low, i_mrg_en_pin, i_mrg_low_pin;
    logic [3:0] i_rail_mrg_en, i_rail_rising, i_rail_ol_en, i_rail_sample_valid;
    pmo_mrg_mode_e [3:0] i_rail_mode;
    logic [3:0][17:0] i_rail_fixed_duty, o_mrg_duty;
    logic [3:0][11:0] i_rail_vmeas, i_rail_vlow, i_rail_vhigh, i_rail_vnom;
    logic [3:0] o_ol_up_out, o_ol_up_oe, o_ol_dn_out, o_ol_dn_oe, o_rail_margined;
    logic sv0;
    logic [11:0] vm0;
    logic [3:1] sv_rest;
    logic [3:1][11:0] vm_rest;
    int errors, total_checks, hi, ri, eq, sb;
    assign i_rail_sample_valid = {sv_rest, sv0};
    assign i_rail_vmeas = {vm_rest, vm0};
    pmo_margining_outputs pmo_margining_outputs_i (.i_clk, .i_rstn, .i_fast_div, .i_fast_duty,
        .i_fast_phase, .i_fast_mode, .i_fast_gpo, .i_fast_restart, .i_fast_pin, .o_fast_out,
        .o_fast_oe, .o_fast_sub, .o_fast_gpi, .i_slow_pwm_en, .i_slow_duty, .i_slow_div,
        .i_slow_pin, .o_slow_out, .o_slow_oe, .o_slow_gpi, .i_mrg_use_pins, .i_mrg_cmd_en,
        .i_mrg_cmd_low, .i_mrg_en_pin, .i_mrg_low_pin, .i_rail_mrg_en, .i_rail_mode,
        .i_rail_rising, .i_rail_ol_en, .i_rail_fixed_duty, .i_rail_sample_valid, .i_rail_vmeas,
        .i_rail_vlow, .i_rail_vhigh, .i_rail_vnom, .o_ol_up_out, .o_ol_up_oe, .o_ol_dn_out,
        .o_ol_dn_oe, .o_rail_margined, .o_mrg_duty);
    pmo_rc_feedback pmo_rc_feedback_i (.i_clk(i_clk), .i_rstn(i_rstn), .i_pin(o_fast_out[0]),
        .i_oe(o_fast_oe[0]), .o_valid(sv0), .o_vmeas(vm0));
    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic summarize();
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value %s expected %0h seen %0h", what, exp, seen);
        end
    endtask
    // Pin select: 0..7 fast, 8..11 slow
    task automatic meas(input int sel, input int n, output int h, output int r);
        logic p;
        logic c;
        h = 0;
        r = 0;
        eq = 0;
        sb = 0;
        p = (sel < 8) ? o_fast_out[sel] : o_slow_out[sel-8];
        repeat (n) begin
            @(negedge i_clk);
            c = (sel < 8) ? o_fast_out[sel] : o_slow_out[sel-8];
            h += int'(c);
            r += int'(c & !p);
            eq += int'(o_fast_out[0] === o_fast_out[1]);
            sb += int'(o_fast_sub[1]);
            p = c;
        end
    endtask
    // Waits out the request latency, then one rail sample moves the duty by delta
    task automatic step(input logic [17:0] delta);
        int n;
        logic [17:0] d;
        n = 0;
        repeat (2) @(negedge i_clk);
        while (sv0 !== 1'b1 && n < 200) begin
            @(negedge i_clk);
            n++;
        end
        if (n == 200) begin
            errors++;
            summarize();
        end
        d = o_mrg_duty[0];
        repeat (3) @(negedge i_clk);
        chk("margin duty", o_mrg_duty[0], 18'(d + delta));
    endtask
    initial begin
        i_clk = 1'b0;
        forever #2 i_clk = ~i_clk;
    end
    // ----------------------------------------
    // Sequence
    // ----------------------------------------
    initial begin
        errors = 0;
        total_checks = 0;
        i_rstn = 1'b0;
        {i_fast_div, i_fast_duty, i_fast_phase, i_fast_gpo, i_fast_restart} = '0;
        i_fast_pin = 8'h5a;
        {i_slow_pwm_en, i_slow_duty, i_slow_div} = '0;
        i_slow_pin = 4'h9;
        {i_mrg_use_pins, i_mrg_cmd_en, i_mrg_cmd_low, i_mrg_en_pin, i_mrg_low_pin} = 5'h0;
        {i_rail_mrg_en, i_rail_rising, i_rail_ol_en, i_rail_fixed_duty} = '0;
        {i_rail_vlow, i_rail_vhigh, i_rail_vnom, sv_rest, vm_rest} = '0;
        for (int k = 0; k < 8; k++) begin
            i_fast_mode[k] = (k < 4) ? PMO_FP_UNUSED : PMO_FP_GPI;
        end
        for (int k = 0; k < 4; k++) begin
            i_rail_mode[k] = PMO_MRG_DISABLE;
        end
        repeat (10) @(negedge i_clk);
        chk("fast out in reset", o_fast_out, 8'h00);
        chk("fast oe in reset", o_fast_oe, 8'hff);
        i_rstn = 1'b1;
        i_fast_mode[0] = PMO_FP_PWM;
        i_fast_mode[1] = PMO_FP_PWM;
        i_fast_mode[2] = PMO_FP_PWM;
        i_fast_mode[4] = PMO_FP_GPO_PUSH;
        i_fast_mode[5] = PMO_FP_GPO_OD;
        i_fast_gpo[4] = 1'b1;
        i_fast_div[1:0] = {14'h4, 14'ha};
        {i_fast_duty[3], i_fast_duty[1], i_fast_duty[0]} = {18'h20, 18'h57, 18'h50};
        i_fast_phase[1] = 14'h5;
        i_fast_restart = 4'h3;
        @(negedge i_clk);
        i_fast_restart = 4'h0;
        repeat (4) @(negedge i_clk);
        chk("push output", o_fast_out[4], 1'b1);
        chk("open drain low", {o_fast_oe[5], o_fast_out[5]}, 2'b10);
        chk("pin input", {o_fast_oe[7:6], o_fast_gpi[6]}, {2'b00, i_fast_pin[6]});
        meas(1, 100, hi, ri);
        chk("fast high time", hi, 50);
        chk("fast periods", ri, 10);
        chk("phase overlap", eq, 0);
        // Sub-step 7 shows once in each of the ten periods
        chk("fast sub steps", sb, 70);
        meas(3, 100, hi, ri);
        chk("companion high time", hi, 50);
        chk("companion periods", ri, 25);
        i_slow_pwm_en = 4'h5;
        {i_slow_duty[2], i_slow_duty[0]} = {24'h1, 24'h64};
        i_slow_div[0] = 24'h3;
        repeat (2) @(negedge i_clk);
        chk("slow directions", o_slow_oe, 4'h5);
        meas(8, 25000, hi, ri);
        chk("slow one high", hi, 100);
        chk("slow one periods", ri, 1);
        meas(10, 480, hi, ri);
        chk("slow three high", hi, 160);
        chk("slow three periods", ri, 10);
        // Long period: fraction 1/65536 of 131072 ticks is two ticks, 17 to 32 clocks high
        i_slow_div[1] = 24'h20000;
        i_slow_duty[3] = 24'h10001;
        i_slow_pwm_en[3] = 1'b1;
        meas(11, 200, hi, ri);
        chk("fine duty", hi > 16 && hi < 33, 1'b1);
        i_rail_fixed_duty[0] = 18'h40;
        i_rail_mode[0] = PMO_MRG_FIXED_DUTY;
        {i_rail_mrg_en, i_rail_rising, i_rail_ol_en} = 12'h111;
        i_rail_vhigh[0] = 12'hfff;
        repeat (3) @(negedge i_clk);
        chk("fixed idle duty", o_mrg_duty[0], 18'h40);
        {i_mrg_cmd_en, i_mrg_cmd_low} = 2'b10;
        repeat (2) @(negedge i_clk);
        chk("command high",
            {o_rail_margined[0], o_ol_up_oe[0], o_ol_dn_oe[0]}, 3'b110);
        step(18'h1);
        i_rail_rising[0] = 1'b0;
        step(18'h3ffff);
        {i_mrg_use_pins, i_mrg_en_pin, i_mrg_low_pin, i_rail_rising[0]} = 4'hf;
        step(18'h3ffff);
        chk("pin low",
            {o_rail_margined[0], o_ol_up_oe[0], o_ol_dn_oe[0]}, 3'b101);
        i_mrg_low_pin = 1'b0;
        repeat (2) @(negedge i_clk);
        chk("pin high", {o_ol_up_oe[0], o_ol_dn_oe[0]}, 2'b10);
        i_mrg_en_pin = 1'b0;
        i_rail_mode[0] = PMO_MRG_TRI_STATE;
        repeat (3) @(negedge i_clk);
        chk("idle released", {o_rail_margined[0], o_fast_oe[0]}, 2'b00);
        i_rail_mode[0] = PMO_MRG_ACTIVE_TRIM;
        i_rail_vnom[0] = 12'hfff;
        step(18'h1);
        i_rail_mode[0] = PMO_MRG_DISABLE;
        i_mrg_en_pin = 1'b1;
        repeat (2) @(negedge i_clk);
        chk("disabled rail", o_rail_margined[0], 1'b0);
        summarize();
    end
endmodule
